// [cmc_regs.vh]
// Purpose: register map, field positions, reset values and frame counts of the converter mode configuration block
// Assumes: included by bare name from every design file that needs it
// Notes:   addresses are the 4-bit serial register addresses
`ifndef CMC_REGS_VH
`define CMC_REGS_VH

// ********************************************************
// register addresses
// ********************************************************
`define CMC_ADDR_MAIN      4'h0
`define CMC_ADDR_I_OFS     4'h2
`define CMC_ADDR_I_FSR     4'h3
`define CMC_ADDR_CAL       4'h4
`define CMC_ADDR_Q_OFS     4'ha
`define CMC_ADDR_Q_FSR     4'hb
`define CMC_ADDR_SYNC      4'he

// ********************************************************
// field positions
// ********************************************************
`define CMC_BIT_CAL        15
`define CMC_BIT_DPS        14
`define CMC_BIT_OVS        13
`define CMC_BIT_TPM        12
`define CMC_BIT_PDI        11
`define CMC_BIT_PDQ        10
`define CMC_BIT_2SC        4
`define CMC_BIT_TSE        3
`define CMC_BIT_SDR        2
`define CMC_BIT_SSC        7
`define CMC_FSR_MSB        14
`define CMC_OFS_MSB        12

// ********************************************************
// reset values
// ********************************************************
`define CMC_RST_MAIN       16'h2000
`define CMC_RST_CAL        16'h0000
`define CMC_RST_OFS        16'h0000
`define CMC_RST_FSR        16'h4000
`define CMC_RST_SYNC       16'h0000
`define CMC_FSR_MID        15'h4000
`define CMC_FSR_MIN        15'h0000
`define CMC_OFS_ZERO       13'h0000
`define CMC_REG_ZERO       16'h0000
`define CMC_SYNC_RST       10'h001

// ********************************************************
// serial frame
// ********************************************************
`define CMC_FRAME_BITS     5'h18
`define CMC_CMD_LAST       5'h07
`define CMC_DATA_LAST      5'h17
`define CMC_RW_POS         6
`define CMC_OUT_SHIFTS     5'h0f
`define CMC_CNT_ZERO       5'h00
`define CMC_CNT_ONE        5'h01

`endif

// [cmc_sync.v]
// Purpose: two-stage synchroniser for a group of asynchronous pins
// Assumes: each bit is an independent level
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module cmc_sync #(
	parameter             WIDTH   = 10,
	parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}} // per-bit idle level: no false activity after reset
) (
	input  wire             mclk_in,   // system clock
	input  wire             rst_n_in,  // async reset, active low
	input  wire [WIDTH-1:0] async_in,  // raw pin levels
	output reg  [WIDTH-1:0] sync_out   // synchronised levels
);

	reg [WIDTH-1:0] meta_q;

	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			meta_q   <= RST_VAL;
			sync_out <= RST_VAL;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule

// [cmc_shreg.v]
// Purpose: msb-first parallel-load shift register for serial read data
// Assumes: load and shift never asserted together; load wins if they are
// Notes:   once emptied it keeps presenting the last bit shifted in (zero)
`timescale 1ns/1ps
module cmc_shreg #(
	parameter WIDTH = 16
) (
	input  wire             mclk_in,   // system clock
	input  wire             rst_n_in,  // async reset, active low
	input  wire             load_in,   // load parallel word
	input  wire             shift_in,  // advance one bit
	input  wire [WIDTH-1:0] data_in,   // parallel word
	output wire             msb_out    // current serial bit
);

	reg [WIDTH-1:0] sh_q;

	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sh_q <= {WIDTH{1'b0}};
		end else if (load_in) begin
			sh_q <= data_in;
		end else if (shift_in) begin
			sh_q <= {sh_q[WIDTH-2:0], 1'b0};
		end
	end

	assign msb_out = sh_q[WIDTH-1];

endmodule

// [cmc_top.v]
// Purpose: mode and feature selection register bank of a dual-channel sampling converter
// Assumes: serial pins and mode pins are asynchronous to mclk_in; sclk well below mclk_in / 4
// Notes:   serial pins are oversampled on mclk_in, so a frame costs no second clock domain
// Function
// - extended mode: main bit 14 sets ddr clock phase or sdr launch edge, default 0.
// - extended mode: main bit 2 selects sdr, ddr after reset; other mode always ddr.
// - extended mode: main bit 13 selects swing, default higher; otherwise higher only.
// - extended mode: main bit 4 selects two's complement; otherwise offset binary always.
// - test pattern from main bit 12 in extended mode, else from its pin; off by default.
// - timestamp only in extended mode via main bit 3, off after reset.
// - calibration from main bit 15 in extended mode; calibration pin works in both modes.
// - calibration value access only in extended mode via calibration register bit 7.
// - i-channel powered down by main bit 11 in extended mode or its pin always.
// - q-channel powered down by main bit 10 in extended mode or its pin always.
// - extended mode full-scale trim is 15 bits; otherwise one pin picks two settings.
// - pin high equals mid-scale trim code, pin low equals minimum trim code.
// - offset trim, sign plus 12-bit magnitude, only in extended mode, default zero.
// - each register access is one 24-bit frame: command then 16-bit data.
`timescale 1ns/1ps
`include "cmc_regs.vh"
module cmc_top #(
	parameter FSR_W = 15,
	parameter OFS_W = 13
) (
	input  wire             mclk_in,                        // system clock, 40 MHz
	input  wire             rst_n_in,                       // async reset, active low
	input  wire             scs_n_in,                       // serial chip select, active low
	input  wire             sclk_in,                        // serial clock pin
	input  wire             sdi_in,                         // serial data in
	output reg              sdo_out,                        // serial data out
	output reg              sdo_oe_out,                     // sdo driven while high
	input  wire             extended_control_mode_in,       // mode select pin
	input  wire             double_rate_phase_pin_in,       // ddr phase pin
	input  wire             test_pattern_pin_in,            // test pattern pin
	input  wire             i_channel_powerdown_pin_in,     // i power-down pin
	input  wire             q_channel_powerdown_pin_in,     // q power-down pin
	input  wire             full_scale_range_pin_in,        // range pin, high = higher range
	input  wire             calibration_pin_in,             // calibration pin
	output reg              output_clock_phase_select_out,  // 0 = 0 deg / rising, 1 = 90 deg / falling
	output reg              sdr_select_out,                 // 1 = single-rate clocking
	output reg              output_swing_select_out,        // 1 = higher swing
	output reg              twos_complement_select_out,     // 1 = two's complement
	output reg              test_pattern_enable_out,        // test pattern on
	output reg              timestamp_enable_out,           // time stamp on
	output reg              calibration_request_out,        // calibration trigger level
	output reg              calibration_value_access_out,   // stored calibration r/w enabled
	output reg              i_channel_powerdown_out,        // i-channel off
	output reg              q_channel_powerdown_out,        // q-channel off
	output reg  [FSR_W-1:0] i_full_scale_range_out,         // i range trim
	output reg  [FSR_W-1:0] q_full_scale_range_out,         // q range trim
	output reg  [OFS_W-1:0] i_offset_trim_out,              // i offset, sign + magnitude
	output reg  [OFS_W-1:0] q_offset_trim_out,              // q offset, sign + magnitude
	output reg  [15:0]      sync_and_clock_reset_control_out // raw sync register contents
);

	// ********************************************************
	// helpers
	// ********************************************************
	function [FSR_W-1:0] fsr_pick;
		input             extended_control_mode;
		input             pin;
		input [15:0]      regv;
		begin
			if (extended_control_mode) begin
				fsr_pick = regv[`CMC_FSR_MSB:0];
			end else if (pin) begin
				fsr_pick = `CMC_FSR_MID;
			end else begin
				fsr_pick = `CMC_FSR_MIN;
			end
		end
	endfunction

	function [OFS_W-1:0] ofs_pick;
		input             extended_control_mode;
		input [15:0]      regv;
		begin
			if (extended_control_mode) begin
				ofs_pick = regv[`CMC_OFS_MSB:0];
			end else begin
				ofs_pick = `CMC_OFS_ZERO;
			end
		end
	endfunction

	// ********************************************************
	// pin synchronisation
	// ********************************************************
	wire [9:0] pins_s;
	wire       scs_n_s;
	wire       sclk_s;
	wire       sdi_s;
	wire       ecm_s;
	wire       double_rate_phase_pin_s;
	wire       tpm_s;
	wire       pdi_s;
	wire       pdq_s;
	wire       fsrp_s;
	wire       calp_s;
	wire       out_bit;

	cmc_sync #(
		.WIDTH   (10),
		.RST_VAL (`CMC_SYNC_RST)
	) u_sync (
		.mclk_in  (mclk_in),
		.rst_n_in (rst_n_in),
		.async_in ({calibration_pin_in, full_scale_range_pin_in, q_channel_powerdown_pin_in,
			i_channel_powerdown_pin_in, test_pattern_pin_in, double_rate_phase_pin_in,
			extended_control_mode_in, sdi_in, sclk_in, scs_n_in}),
		.sync_out (pins_s)
	);

	assign scs_n_s = pins_s[0];
	assign sclk_s  = pins_s[1];
	assign sdi_s   = pins_s[2];
	assign ecm_s   = pins_s[3];
	assign double_rate_phase_pin_s = pins_s[4];
	assign tpm_s   = pins_s[5];
	assign pdi_s   = pins_s[6];
	assign pdq_s   = pins_s[7];
	assign fsrp_s  = pins_s[8];
	assign calp_s  = pins_s[9];

	// edge detect works on the synchronised copy only
	reg  sclk_d1_q;
	wire sclk_rise = sclk_s & ~sclk_d1_q;
	wire sclk_fall = ~sclk_s & sclk_d1_q;

	// ********************************************************
	// serial frame state machine
	// ********************************************************
	localparam [3:0] ST_IDLE = 4'h1;
	localparam [3:0] ST_CMD  = 4'h2;
	localparam [3:0] ST_DATA = 4'h4;
	localparam [3:0] ST_DONE = 4'h8;

	reg [3:0]  state_q, state_d;
	reg [4:0]  bit_cnt_q;
	reg [4:0]  fall_cnt_q;
	reg [23:0] shift_q;
	reg        rd_q;
	reg [3:0]  addr_q;
	reg        drive_q;
	reg [15:0] rd_data;

	reg [15:0] main_configuration_q;
	reg [15:0] calibration_adjust_q;
	reg [15:0] i_offset_adjust_q;
	reg [15:0] i_range_adjust_q;
	reg [15:0] q_offset_adjust_q;
	reg [15:0] q_range_adjust_q;
	reg [15:0] sync_and_clock_reset_control_q;

	wire       cmd_done = sclk_rise & (bit_cnt_q == `CMC_CMD_LAST);
	wire       wr_now   = sclk_rise & (bit_cnt_q == `CMC_DATA_LAST) & state_q[3] == 1'b0 & ~rd_q;
	wire [15:0] wr_data = {shift_q[14:0], sdi_s};
	wire       first_fall = sclk_fall & state_q[2] & rd_q & ~drive_q;
	wire       next_fall  = sclk_fall & drive_q & (fall_cnt_q != `CMC_OUT_SHIFTS);

	always @* begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (!scs_n_s) begin
					state_d = ST_CMD;
				end
			end
			ST_CMD: begin
				if (scs_n_s) begin
					state_d = ST_IDLE;
				end else if (cmd_done) begin
					state_d = ST_DATA;
				end
			end
			ST_DATA: begin
				if (scs_n_s) begin
					state_d = ST_IDLE; // short frame: nothing written
				end else if (sclk_rise && bit_cnt_q == `CMC_DATA_LAST) begin
					state_d = ST_DONE;
				end
			end
			ST_DONE: begin
				// chip select must toggle before the next frame
				if (scs_n_s) begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always @* begin
		case (shift_q[3:0])
			`CMC_ADDR_MAIN:  rd_data = main_configuration_q;
			`CMC_ADDR_I_OFS: rd_data = i_offset_adjust_q;
			`CMC_ADDR_I_FSR: rd_data = i_range_adjust_q;
			`CMC_ADDR_CAL:   rd_data = calibration_adjust_q;
			`CMC_ADDR_Q_OFS: rd_data = q_offset_adjust_q;
			`CMC_ADDR_Q_FSR: rd_data = q_range_adjust_q;
			`CMC_ADDR_SYNC:  rd_data = sync_and_clock_reset_control_q;
			default:         rd_data = `CMC_REG_ZERO;
		endcase
	end

	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_q    <= ST_IDLE;
			sclk_d1_q  <= 1'b0;
			bit_cnt_q  <= `CMC_CNT_ZERO;
			fall_cnt_q <= `CMC_CNT_ZERO;
			shift_q    <= 24'h000000;
			rd_q       <= 1'b0;
			addr_q     <= 4'h0;
			drive_q    <= 1'b0;
		end else begin
			state_q   <= state_d;
			sclk_d1_q <= sclk_s;
			if (state_q == ST_IDLE) begin
				bit_cnt_q  <= `CMC_CNT_ZERO;
				fall_cnt_q <= `CMC_CNT_ZERO;
				rd_q       <= 1'b0;
				drive_q    <= 1'b0;
			end else begin
				if (sclk_rise && bit_cnt_q != `CMC_FRAME_BITS) begin
					bit_cnt_q <= bit_cnt_q + `CMC_CNT_ONE;
					shift_q   <= {shift_q[22:0], sdi_s};
				end
				if (cmd_done) begin
					rd_q   <= shift_q[`CMC_RW_POS];
					addr_q <= shift_q[3:0];
				end
				if (first_fall) begin
					drive_q <= 1'b1;
				end
				if (next_fall) begin
					fall_cnt_q <= fall_cnt_q + `CMC_CNT_ONE;
				end
			end
		end
	end

	// msb first; after d0 the line holds d0 until chip select rises
	cmc_shreg #(
		.WIDTH (16)
	) u_out (
		.mclk_in  (mclk_in),
		.rst_n_in (rst_n_in),
		.load_in  (cmd_done),
		.shift_in (next_fall),
		.data_in  (rd_data),
		.msb_out  (out_bit)
	);

	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sdo_out    <= 1'b0;
			sdo_oe_out <= 1'b0;
		end else begin
			sdo_out    <= out_bit;
			sdo_oe_out <= drive_q & ~scs_n_s;
		end
	end

	// ********************************************************
	// register file
	// ********************************************************
	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			main_configuration_q           <= `CMC_RST_MAIN;
			calibration_adjust_q           <= `CMC_RST_CAL;
			i_offset_adjust_q              <= `CMC_RST_OFS;
			i_range_adjust_q               <= `CMC_RST_FSR;
			q_offset_adjust_q              <= `CMC_RST_OFS;
			q_range_adjust_q               <= `CMC_RST_FSR;
			sync_and_clock_reset_control_q <= `CMC_RST_SYNC;
		end else if (wr_now) begin
			case (addr_q)
				`CMC_ADDR_MAIN:  main_configuration_q           <= wr_data;
				`CMC_ADDR_I_OFS: i_offset_adjust_q              <= wr_data;
				`CMC_ADDR_I_FSR: i_range_adjust_q               <= wr_data;
				`CMC_ADDR_CAL:   calibration_adjust_q           <= wr_data;
				`CMC_ADDR_Q_OFS: q_offset_adjust_q              <= wr_data;
				`CMC_ADDR_Q_FSR: q_range_adjust_q               <= wr_data;
				`CMC_ADDR_SYNC:  sync_and_clock_reset_control_q <= wr_data;
				default: begin
				end
			endcase
		end
	end

	// ********************************************************
	// feature selection
	// ********************************************************
	// registers keep their contents across mode changes; only the selection moves
	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			output_clock_phase_select_out    <= 1'b0;
			sdr_select_out                   <= 1'b0;
			output_swing_select_out          <= 1'b1;
			twos_complement_select_out       <= 1'b0;
			test_pattern_enable_out          <= 1'b0;
			timestamp_enable_out             <= 1'b0;
			calibration_request_out          <= 1'b0;
			calibration_value_access_out     <= 1'b0;
			i_channel_powerdown_out          <= 1'b0;
			q_channel_powerdown_out          <= 1'b0;
			i_full_scale_range_out           <= `CMC_FSR_MID;
			q_full_scale_range_out           <= `CMC_FSR_MID;
			i_offset_trim_out                <= `CMC_OFS_ZERO;
			q_offset_trim_out                <= `CMC_OFS_ZERO;
			sync_and_clock_reset_control_out <= `CMC_RST_SYNC;
		end else begin
			output_clock_phase_select_out <= ecm_s ? main_configuration_q[`CMC_BIT_DPS] : double_rate_phase_pin_s;
			sdr_select_out               <= ecm_s & main_configuration_q[`CMC_BIT_SDR];
			output_swing_select_out      <= ~ecm_s | main_configuration_q[`CMC_BIT_OVS];
			twos_complement_select_out   <= ecm_s & main_configuration_q[`CMC_BIT_2SC];
			test_pattern_enable_out      <= ecm_s ? main_configuration_q[`CMC_BIT_TPM] : tpm_s;
			timestamp_enable_out         <= ecm_s & main_configuration_q[`CMC_BIT_TSE];
			calibration_request_out      <= calp_s | (ecm_s & main_configuration_q[`CMC_BIT_CAL]);
			calibration_value_access_out <= ecm_s & calibration_adjust_q[`CMC_BIT_SSC];
			i_channel_powerdown_out      <= pdi_s | (ecm_s & main_configuration_q[`CMC_BIT_PDI]);
			q_channel_powerdown_out      <= pdq_s | (ecm_s & main_configuration_q[`CMC_BIT_PDQ]);
			i_full_scale_range_out       <= fsr_pick(ecm_s, fsrp_s, i_range_adjust_q);
			q_full_scale_range_out       <= fsr_pick(ecm_s, fsrp_s, q_range_adjust_q);
			i_offset_trim_out            <= ofs_pick(ecm_s, i_offset_adjust_q);
			q_offset_trim_out            <= ofs_pick(ecm_s, q_offset_adjust_q);
			sync_and_clock_reset_control_out <= sync_and_clock_reset_control_q;
		end
	end

endmodule

// [cmc_top_sva.sv]
// Purpose: port assertions for the converter mode configuration bank
// Assumes: mode pins pass 2 sync stages and 1 output register
// Notes:   each mode and feature pin check holds its cause for 4 cycles; sdo_idle_a holds chip select for 5
`timescale 1ns/1ps
module cmc_top_sva #(
	parameter FSR_W = 15,
	parameter OFS_W = 13
) (
	input wire             mclk_in,                    // clock
	input wire             rst_n_in,                   // reset
	input wire             scs_n_in,                   // select
	input wire             extended_control_mode_in,   // mode pin
	input wire             calibration_pin_in,         // cal pin
	input wire             i_channel_powerdown_pin_in, // i pin
	input wire             full_scale_range_pin_in,    // range pin
	input wire             sdo_oe_out,                 // sdo enable
	input wire             sdr_select_out,             // sdr
	input wire             output_swing_select_out,    // swing
	input wire             twos_complement_select_out, // coding
	input wire             timestamp_enable_out,       // stamp
	input wire             calibration_request_out,    // cal
	input wire             calibration_value_access_out, // cal access
	input wire             i_channel_powerdown_out,    // i down
	input wire [FSR_W-1:0] i_full_scale_range_out,     // i range
	input wire [OFS_W-1:0] i_offset_trim_out           // i offset
);
	// ********************************
	// mode selection, feature pin and sdo enable checks
	// ********************************
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!rst_n_in);
	sequence std_mode;
		!extended_control_mode_in [*4];
	endsequence
	sdr_ddr_only_a: assert property (std_mode |-> !sdr_select_out)
		else $error("single-rate output outside extended mode");
	swing_high_only_a: assert property (std_mode |-> output_swing_select_out)
		else $error("low swing outside extended mode");
	offset_binary_a: assert property (std_mode |-> !twos_complement_select_out)
		else $error("two's complement outside extended mode");
	stamp_off_a: assert property (std_mode |-> !timestamp_enable_out)
		else $error("time stamp outside extended mode");
	value_access_off_a: assert property (std_mode |-> !calibration_value_access_out)
		else $error("calibration value access outside extended mode");
	offset_zero_a: assert property (std_mode |-> i_offset_trim_out == 'h0)
		else $error("offset trim nonzero outside extended mode");
	cal_pin_a: assert property (calibration_pin_in [*4] |-> calibration_request_out)
		else $error("calibration pin ignored");
	i_pin_down_a: assert property (i_channel_powerdown_pin_in [*4] |-> i_channel_powerdown_out)
		else $error("i power-down pin ignored");
	fsr_pin_mid_a: assert property ((!extended_control_mode_in && full_scale_range_pin_in) [*4]
		|-> i_full_scale_range_out == 'h4000) else $error("range pin high is not mid-scale");
	fsr_pin_min_a: assert property ((!extended_control_mode_in && !full_scale_range_pin_in) [*4]
		|-> i_full_scale_range_out == 'h0) else $error("range pin low is not minimum");
	sdo_idle_a: assert property (scs_n_in [*5] |-> !sdo_oe_out)
		else $error("sdo driven without a frame");
	oe_in_frame_a: assert property ($rose(sdo_oe_out) |-> !scs_n_in)
		else $error("sdo enabled outside a frame");
	cover property ($rose(sdr_select_out));
	cover property ($rose(sdo_oe_out));
	cover property ($rose(calibration_request_out) && extended_control_mode_in);
endmodule

bind cmc_top cmc_top_sva #(.FSR_W(FSR_W), .OFS_W(OFS_W)) i_cmc_top_sva (
	.mclk_in(mclk_in), .rst_n_in(rst_n_in), .scs_n_in(scs_n_in),
	.extended_control_mode_in(extended_control_mode_in), .calibration_pin_in(calibration_pin_in),
	.i_channel_powerdown_pin_in(i_channel_powerdown_pin_in), .full_scale_range_pin_in(full_scale_range_pin_in),
	.sdo_oe_out(sdo_oe_out), .sdr_select_out(sdr_select_out), .output_swing_select_out(output_swing_select_out),
	.twos_complement_select_out(twos_complement_select_out), .timestamp_enable_out(timestamp_enable_out),
	.calibration_request_out(calibration_request_out),
	.calibration_value_access_out(calibration_value_access_out),
	.i_channel_powerdown_out(i_channel_powerdown_out), .i_full_scale_range_out(i_full_scale_range_out),
	.i_offset_trim_out(i_offset_trim_out));

// [cmc_host.sv]
// Purpose: serial host model issuing 24-bit register frames
// Assumes: sclk half period of HALF mclk cycles, at least 5
// Notes:   sclk idles low; idle sdi shows the inverse of its last bit
`timescale 1ns/1ps
module cmc_host #(
	parameter HALF = 8
) (
	input  wire  mclk_in,   // system clock
	input  wire  sdo_in,    // serial read data
	input  wire  sdo_oe_in, // read data driven
	output logic scs_n_out, // chip select, active low
	output logic sclk_out,  // serial clock
	output logic sdi_out    // serial write data
);
	initial begin
		scs_n_out = 1'b1;
		sclk_out = 1'b0;
		sdi_out = 1'b0;
	end
	// nbits below 24 cuts the frame short
	task automatic frame(input logic rw, input logic [3:0] addr, input logic [15:0] wdata,
		input int nbits, output logic [15:0] rdata);
		logic [23:0] bits;
		bits = {rw, 2'b10, addr, 1'b0, wdata};
		rdata = 16'h0000;
		@(posedge mclk_in);
		scs_n_out <= 1'b0;
		for (int k = 0; k < nbits; k++) begin
			sdi_out <= bits[23-k];
			repeat (HALF) @(posedge mclk_in);
			if (k > 7)
				rdata = {rdata[14:0], (sdo_oe_in === 1'b1) ? sdo_in : 1'bx};
			sclk_out <= 1'b1;
			repeat (HALF) @(posedge mclk_in);
			sclk_out <= 1'b0;
		end
		repeat (HALF) @(posedge mclk_in);
		scs_n_out <= 1'b1;
		sdi_out <= ~sdi_out;
		repeat (HALF) @(posedge mclk_in);
	endtask
endmodule

// [tb_converter_mode_config.sv]
// Purpose: self-checking bench for the converter mode configuration bank
// Assumes: registers hold all written bits; range and offset writes stay in field
// Notes:   expectations come from a shadow register file
`timescale 1ns/1ps
module tb_converter_mode_config;
	localparam int LIMIT = 80000;
	localparam logic [15:0] MAPPED = 16'h4c1d;
	logic        mclk_in = 1'b0;
	logic        rst_n = 1'b0;
	logic        extended_control_mode = 1'b0;
	logic [5:0]  pins = 6'h00; // ddr phase, pattern, i down, q down, range, cal
	wire         scs_n, sclk, sdi, sdo, sdo_oe;
	wire [9:0]   feat;
	wire [14:0]  i_fsr, q_fsr;
	wire [12:0]  i_ofs, q_ofs;
	wire [15:0]  sync_reg;
	logic [15:0] regs_s [16];
	logic [15:0] rdata;
	int          fails = 0;
	int          check_count = 0;
	int          cycles = 0;

	always #12.5 mclk_in = ~mclk_in;

	cmc_top i_cmc_top (.mclk_in(mclk_in), .rst_n_in(rst_n), .scs_n_in(scs_n), .sclk_in(sclk), .sdi_in(sdi),
		.sdo_out(sdo), .sdo_oe_out(sdo_oe), .extended_control_mode_in(extended_control_mode),
		.double_rate_phase_pin_in(pins[5]), .test_pattern_pin_in(pins[4]),
		.i_channel_powerdown_pin_in(pins[3]), .q_channel_powerdown_pin_in(pins[2]),
		.full_scale_range_pin_in(pins[1]), .calibration_pin_in(pins[0]),
		.output_clock_phase_select_out(feat[9]), .sdr_select_out(feat[8]), .output_swing_select_out(feat[7]),
		.twos_complement_select_out(feat[6]), .test_pattern_enable_out(feat[5]), .timestamp_enable_out(feat[4]),
		.calibration_request_out(feat[3]), .calibration_value_access_out(feat[2]),
		.i_channel_powerdown_out(feat[1]), .q_channel_powerdown_out(feat[0]),
		.i_full_scale_range_out(i_fsr), .q_full_scale_range_out(q_fsr), .i_offset_trim_out(i_ofs),
		.q_offset_trim_out(q_ofs), .sync_and_clock_reset_control_out(sync_reg));

	cmc_host i_cmc_host (.mclk_in(mclk_in), .sdo_in(sdo), .sdo_oe_in(sdo_oe), .scs_n_out(scs_n),
		.sclk_out(sclk), .sdi_out(sdi));

	task automatic end_sim;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [3:0] addr, input logic [15:0] data);
		i_cmc_host.frame(1'b0, addr, data, 24, rdata);
		if (MAPPED[addr])
			regs_s[addr] = data;
		repeat (4) @(posedge mclk_in);
	endtask

	task automatic rd(input logic [3:0] addr);
		i_cmc_host.frame(1'b1, addr, 16'ha5a5, 24, rdata);
		check("read data", rdata, MAPPED[addr] ? regs_s[addr] : 16'h0000);
	endtask

	task automatic check_outs;
		logic [9:0]  v;
		logic [15:0] m;
		m = regs_s[0];
		v = {extended_control_mode ? m[14] : pins[5], extended_control_mode & m[2], ~extended_control_mode | m[13], extended_control_mode & m[4], extended_control_mode ? m[12] : pins[4],
			extended_control_mode & m[3], pins[0] | (extended_control_mode & m[15]), extended_control_mode & regs_s[4][7], pins[3] | (extended_control_mode & m[11]),
			pins[2] | (extended_control_mode & m[10])};
		check("features", {6'h00, feat}, {6'h00, v});
		check("i range", {1'b0, i_fsr}, extended_control_mode ? regs_s[3] : {1'b0, pins[1], 14'h0000});
		check("q range", {1'b0, q_fsr}, extended_control_mode ? regs_s[11] : {1'b0, pins[1], 14'h0000});
		check("i offset", {3'h0, i_ofs}, extended_control_mode ? regs_s[2] : 16'h0000);
		check("q offset", {3'h0, q_ofs}, extended_control_mode ? regs_s[10] : 16'h0000);
		check("sync reg", sync_reg, regs_s[14]);
	endtask

	always @(posedge mclk_in) begin
		cycles++;
		if (cycles == LIMIT) begin
			fails++;
			end_sim;
		end
	end

	initial begin
		for (int a = 0; a < 16; a++)
			regs_s[a] = 16'h0000;
		regs_s[0] = 16'h2000;
		regs_s[3] = 16'h4000;
		regs_s[11] = 16'h4000;
		repeat (5) @(posedge mclk_in);
		rst_n <= 1'b1;
		repeat (5) @(posedge mclk_in);
		check_outs;
		for (int a = 0; a < 16; a++)
			rd(a[3:0]);
		$display("test reset values done");
		wr(4'h4, 16'h0080);
		for (int s = 0; s < 4; s++) begin
			extended_control_mode <= s[1];
			pins <= s[0] ? 6'h2a : 6'h15;
			for (int b = 0; b < 16; b++) begin
				wr(4'h0, 16'h0001 << b);
				check_outs;
			end
		end
		$display("test feature bits done");
		wr(4'h3, 16'h1234);
		wr(4'hb, 16'h7fff);
		wr(4'h2, 16'h1abc);
		wr(4'ha, 16'h0fff);
		wr(4'he, 16'h00c3);
		wr(4'h4, 16'h0000);
		// host recalibrates after a range change
		wr(4'h0, 16'h8000);
		for (int s = 0; s < 4; s++) begin
			extended_control_mode <= s[1];
			pins <= s[0] ? 6'h2a : 6'h15;
			repeat (5) @(posedge mclk_in);
			check_outs;
		end
		for (int a = 0; a < 16; a++)
			rd(a[3:0]);
		$display("test trims done");
		wr(4'h1, 16'hffff);
		// frames cut short before the last data bit must not write
		i_cmc_host.frame(1'b0, 4'h0, 16'h5555, 12, rdata);
		i_cmc_host.frame(1'b0, 4'h0, 16'h5555, 23, rdata);
		rd(4'h0);
		rd(4'h1);
		$display("test refused frames done");
		end_sim;
	end
endmodule
